/* core/adcseq_pkg.sv */
// Purpose: Shared constants and types for the conversion sequencer
// Assumes: 100 MHz system clock, classic Wishbone register access
// Notes:   Byte addresses are four times the register index
package adcseq_pkg;
    // Register indices
    localparam logic [3:0] ADCSEQ_IDX_RESULT_LO = 4'h4;
    localparam logic [3:0] ADCSEQ_IDX_RESULT_HI = 4'h5;
    localparam logic [3:0] ADCSEQ_IDX_CTRL      = 4'h6;
    localparam logic [3:0] ADCSEQ_IDX_MUX       = 4'h7;
    // Control/status field positions
    localparam int ADCSEQ_CTL_EN   = 7;
    localparam int ADCSEQ_CTL_SC   = 6;
    localparam int ADCSEQ_CTL_FR   = 5;
    localparam int ADCSEQ_CTL_DONE = 4;
    localparam int ADCSEQ_CTL_IE   = 3;
    // Multiplexer field positions
    localparam int ADCSEQ_MUX_REF_HI = 7;
    localparam int ADCSEQ_MUX_REF_LO = 6;
    localparam int ADCSEQ_MUX_LEFT   = 5;
    // Reset values
    localparam logic [7:0] ADCSEQ_MUX_RESET  = 8'h00;
    localparam logic [7:0] ADCSEQ_CTRL_RESET = 8'h00;
    // Conversion lengths in converter clock cycles
    localparam logic [4:0] ADCSEQ_LEN_NORMAL   = 5'h0d;
    localparam logic [4:0] ADCSEQ_LEN_EXTENDED = 5'h19;
    // Sample instant, in converter clock cycles, counted in half cycles
    localparam logic [5:0] ADCSEQ_SAMPLE_NORMAL_HALF   = 6'h03;
    localparam logic [5:0] ADCSEQ_SAMPLE_EXTENDED_HALF = 6'h1b;
    // Channel codes from this one through ADCSEQ_DIFF_LAST are differential pairs
    localparam logic [4:0] ADCSEQ_DIFF_FIRST = 5'h0b;
    localparam logic [4:0] ADCSEQ_DIFF_LAST  = 5'h1d;

    // Reference select encodings
    typedef enum logic [1:0] {
        ADCSEQ_REF_SUPPLY, ADCSEQ_REF_EXT_PIN,
        ADCSEQ_REF_INT_OPEN, ADCSEQ_REF_INT_CAP
    } adcseq_ref_t;

    // Settings handed to the analog front end for one conversion
    typedef struct packed {
        logic [1:0] ref_sel;
        logic [4:0] chan_gain;
    } adcseq_front_t;
endpackage

/* core/adcseq_result_mem.sv */
// Purpose: Two-byte result holder with registered read data
// Assumes: Written only on completion of a conversion
// Notes:   Read data reformats on the clock after alignment changes
`timescale 1ns/1ns
module adcseq_result_mem
    import adcseq_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Write side
    input  wire logic       wr_i,
    input  wire logic [9:0] wr_data_i,
    // Read side
    input  wire logic       left_i,
    output logic      [7:0] lo_o,
    output logic      [7:0] hi_o
);
    logic [9:0] word_reg;

    // Stored 10-bit result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_reg <= 10'h000;
        end else if (wr_i) begin
            word_reg <= wr_data_i;
        end
    end

    // Registered byte view follows the alignment bit every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lo_o <= 8'h00;
            hi_o <= 8'h00;
        end else if (left_i) begin
            lo_o <= {word_reg[1:0], 6'h00};
            hi_o <= word_reg[9:2];
        end else begin
            lo_o <= word_reg[7:0];
            hi_o <= {6'h00, word_reg[9:8]};
        end
    end
endmodule

/* core/adcseq_top.sv */
// Purpose: Conversion sequencer for a 10-bit successive-approximation ADC
// Assumes: Wishbone classic slave, front end returns a finished code
// Notes:   One converter clock tick equals one prescaler wrap
// Functional notes
// - Prescaler counts while enabled, held in reset while disabled.
// - A start begins on the next rising converter clock edge.
// - Differential pairs start only on alternate converter edges after enable.
// - Normal conversion lasts 13 converter clock cycles.
// - First conversion after enable runs a 25-cycle extended pass, then a normal 13-cycle pass.
// - Sample at 1.5 cycles normally, 13.5 cycles extended.
// - Completion writes result registers and sets done flag.
// - Single mode clears start bit as done flag sets.
// - Free-run relaunches at once and start bit stays high.
// - Configured converter starts automatically when CPU sleeps quietly.
// - Sleep conversion completion wakes the CPU unless woken already.
// - Single-ended code is Vin times 1024 over reference.
// - Differential code is difference times gain, floored at zero.
// - Mux register: reference 7:6, left align 5, channel 4:0.
// - Reference changes apply only after the current conversion.
// - Reference codes: supply, external pin, internal open, internal cap.
// - Result right adjusted by default, left when align bit set.
// - Align bit reformats result registers immediately; here the registered byte view follows one clock later.
// - Writing one starts; zero ignored; bit reads one until real finish.
// - Done flag clears on vector execution or written one.
// - Clearing enable aborts conversion and switches converter off.
// - Free-run bit gives continuous conversions; clearing ends them.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
module adcseq_top
    import adcseq_pkg::*;
#(
    parameter int PRESCALE_W = 7
)(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Wishbone classic slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [5:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    // CPU side
    input  wire logic             cpu_quiet_sleep_i,
    input  wire logic             vector_taken_i,
    output logic                  done_irq_o,
    output logic                  wake_o,
    // Analog front end
    input  wire logic [9:0]       code_i,
    output logic                  analog_on_o,
    output logic                  sample_o,
    output adcseq_front_t         front_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_CONV} adcseq_state_t;

    // Differential decode, used on the live multiplexer channel field
    function automatic logic is_diff(input logic [4:0] c);
        is_diff = (c >= ADCSEQ_DIFF_FIRST) && (c <= ADCSEQ_DIFF_LAST);
    endfunction

    adcseq_state_t       state_reg;
    logic [7:0]          mux_reg;
    logic                en_reg, sc_reg, fr_reg, done_reg, ie_reg;
    logic [2:0]          div_reg;
    logic [PRESCALE_W-1:0] pre_reg;
    logic                tick, half_tick, parity_reg, first_reg, ext_reg;
    logic                sleep_arm_reg, ack_reg;
    logic [4:0]          cnt_reg, len;
    logic [5:0]          half_reg;
    logic                wr_hit, wr_ctrl, wr_mux, finish, can_start;
    logic [PRESCALE_W-1:0] div_top;
    logic [7:0]          res_lo, res_hi;
    logic [3:0]          idx;

    assign idx     = adr_i[5:2];
    assign wr_hit  = cyc_i && stb_i && we_i && ack_reg && sel_i[0];
    assign wr_ctrl = wr_hit && (idx == ADCSEQ_IDX_CTRL);
    assign wr_mux  = wr_hit && (idx == ADCSEQ_IDX_MUX);
    // Divider select 0 and 1 both divide by two
    assign div_top = (div_reg == 3'h0) ? PRESCALE_W'(1)
                   : PRESCALE_W'((1 << div_reg) - 1);
    assign tick      = en_reg && (pre_reg == div_top);
    assign half_tick = en_reg && (pre_reg == (div_top >> 1));
    assign len = ext_reg ? ADCSEQ_LEN_EXTENDED : ADCSEQ_LEN_NORMAL;
    assign finish = (state_reg == ST_CONV) && tick && (cnt_reg == len - 5'h01);
    // Start gating on converter edges
    assign can_start = tick && en_reg && (sc_reg || sleep_arm_reg)
        && (!is_diff(mux_reg[4:0]) || parity_reg);

    // Prescaler, held in reset while disabled
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_reg) begin
            pre_reg <= '0;
        end else if (tick) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + PRESCALE_W'(1);
        end
    end

    // Alternate-edge marker counted from enable
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_reg) begin
            parity_reg <= 1'b0;
        end else if (tick) begin
            parity_reg <= !parity_reg;
        end
    end

    // Sequencer state and cycle counter
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_reg) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 5'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (can_start) begin
                        state_reg <= ST_CONV;
                        cnt_reg   <= 5'h00;
                    end
                end
                ST_CONV: begin
                    if (finish && !(fr_reg && !first_reg)) begin
                        // Extended pass chains into the real one
                        state_reg <= ext_reg ? ST_CONV : ST_IDLE;
                        cnt_reg   <= 5'h00;
                    end else if (finish) begin
                        cnt_reg <= 5'h00;
                    end else if (tick) begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // First conversion after enable is extended
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_reg) begin
            first_reg <= 1'b1;
            ext_reg   <= 1'b0;
        end else if (state_reg == ST_IDLE && can_start) begin
            ext_reg <= first_reg;
        end else if (finish) begin
            ext_reg   <= 1'b0;
            first_reg <= 1'b0;
        end
    end

    // Sample instant counted in half converter cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_reg || state_reg != ST_CONV || finish) begin
            half_reg <= 6'h00;
            sample_o <= 1'b0;
        end else begin
            if (tick || half_tick) begin
                half_reg <= half_reg + 6'h01;
            end
            sample_o <= (tick || half_tick) && (half_reg + 6'h01 == (ext_reg
                ? ADCSEQ_SAMPLE_EXTENDED_HALF
                : ADCSEQ_SAMPLE_NORMAL_HALF));
        end
    end

    // Front-end settings latched only between conversions
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            front_o <= '0;
        end else if (state_reg == ST_IDLE || finish) begin
            front_o.ref_sel   <= mux_reg[ADCSEQ_MUX_REF_HI:ADCSEQ_MUX_REF_LO];
            front_o.chan_gain <= mux_reg[4:0];
        end
    end

    // Multiplexer register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mux_reg <= ADCSEQ_MUX_RESET;
        end else if (wr_mux) begin
            mux_reg <= dat_i[7:0];
        end
    end

    // Control bits other than start and done
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {en_reg, fr_reg, ie_reg, div_reg} <= 6'h00;
        end else if (wr_ctrl) begin
            en_reg  <= dat_i[ADCSEQ_CTL_EN];
            fr_reg  <= dat_i[ADCSEQ_CTL_FR];
            ie_reg  <= dat_i[ADCSEQ_CTL_IE];
            div_reg <= dat_i[2:0];
        end
    end

    // Start bit: set by writing one, cleared by hardware
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sc_reg <= 1'b0;
        end else if (wr_ctrl && dat_i[ADCSEQ_CTL_SC]
                     && dat_i[ADCSEQ_CTL_EN]) begin
            sc_reg <= 1'b1;
        end else if (!en_reg || (finish && !ext_reg && !fr_reg)) begin
            sc_reg <= 1'b0;
        end
    end

    // Sleep-time auto start
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_reg) begin
            sleep_arm_reg <= 1'b0;
        end else if (cpu_quiet_sleep_i && state_reg == ST_IDLE && !sc_reg
                     && !fr_reg && ie_reg && !sleep_arm_reg) begin
            sleep_arm_reg <= 1'b1;
        end else if (can_start || !cpu_quiet_sleep_i) begin
            sleep_arm_reg <= 1'b0;
        end
    end

    // Done flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else if (finish && !ext_reg) begin
            done_reg <= 1'b1;
        end else if (vector_taken_i
                     || (wr_ctrl && dat_i[ADCSEQ_CTL_DONE])) begin
            done_reg <= 1'b0;
        end
    end

    // Interrupt, wake and analog power outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_irq_o  <= 1'b0;
            wake_o      <= 1'b0;
            analog_on_o <= 1'b0;
        end else begin
            done_irq_o  <= done_reg && ie_reg;
            wake_o      <= finish && !ext_reg && ie_reg
                           && cpu_quiet_sleep_i;
            analog_on_o <= en_reg;
        end
    end

    // Result store; front end supplies the scaled code
    adcseq_result_mem u_mem (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_i      (finish && !ext_reg),
        .wr_data_i (code_i),
        .left_i    (mux_reg[ADCSEQ_MUX_LEFT]),
        .lo_o      (res_lo),
        .hi_o      (res_hi)
    );

    // Bus answer one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_o   <= 32'h0000_0000;
        end else begin
            ack_reg <= cyc_i && stb_i && !ack_reg;
            if (idx == ADCSEQ_IDX_RESULT_LO) begin
                dat_o <= {24'h00_0000, res_lo};
            end else if (idx == ADCSEQ_IDX_RESULT_HI) begin
                dat_o <= {24'h00_0000, res_hi};
            end else if (idx == ADCSEQ_IDX_CTRL) begin
                dat_o <= {24'h00_0000, en_reg, sc_reg, fr_reg, done_reg,
                          ie_reg, div_reg};
            end else if (idx == ADCSEQ_IDX_MUX) begin
                dat_o <= {24'h00_0000, mux_reg};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end
    assign ack_o = ack_reg;

    // Start bit stays high through a completion in free-run
    fr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (finish && fr_reg && en_reg && !ext_reg) |=> sc_reg)
        else $error("start bit dropped in free-run");
    // Done flag follows a real completion
    done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (finish && !ext_reg) |=> done_reg)
        else $error("done flag not set");
    // Single mode clears start with completion
    single_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (finish && !ext_reg && !fr_reg && !wr_ctrl) |=> !sc_reg)
        else $error("start bit not cleared");
    // Disabled prescaler sits at zero
    pre_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!en_reg && !$past(en_reg)) |-> pre_reg == '0)
        else $error("prescaler ran while disabled");
    // Disable aborts conversion
    abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_reg |=> state_reg == ST_IDLE)
        else $error("conversion survived disable");
    // Length selection
    len_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        finish |-> cnt_reg == (first_reg ? 5'h18 : 5'h0c))
        else $error("wrong conversion length");
    // Differential start only on alternate edge
    diff_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == ST_IDLE && tick && !parity_reg
         && is_diff(mux_reg[4:0])) |=> state_reg == ST_IDLE)
        else $error("differential start on wrong edge");
    // Multiplexer reset value
    mux_reset_a: assert property (@(posedge clk_i)
        rst_i |=> mux_reg == ADCSEQ_MUX_RESET)
        else $error("mux register not reset");
endmodule

/* test/adcseq_front_model.sv */
// Purpose: Analog front end stand-in for the sequencer bench
// Assumes: The code is latched at the sample-and-hold instant
// Notes:   Code mirrors reference and channel so routing shows up
`timescale 1ns/1ns
module adcseq_front_model
    import adcseq_pkg::*;
(
    // Clock
    input  wire logic          clk_i,
    // Sequencer side
    input  wire logic          analog_on_i,
    input  wire logic          sample_i,
    input  wire adcseq_front_t front_i,
    output logic [9:0]         code_o
);
    // Start from a non-zero pattern so stale zeros never match
    initial code_o = 10'h2A5;

    // Hold the sampled code, scramble it every cycle while powered down
    always @(posedge clk_i) begin
        if (!analog_on_i) begin
            code_o <= ~code_o;
        end else if (sample_i) begin
            code_o <= {front_i.ref_sel, front_i.chan_gain, 3'b101};
        end
    end
endmodule

/* test/adcseq_tb_top.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Fastest divider, two system clocks per converter tick
// Notes:   Bus tasks wait for ack; all spans come from system clock counts
`timescale 1ns/1ns
module adcseq_tb_top
    import adcseq_pkg::*;
;
    localparam logic [5:0] A_LO = {ADCSEQ_IDX_RESULT_LO, 2'b00};
    localparam logic [5:0] A_HI = {ADCSEQ_IDX_RESULT_HI, 2'b00};
    localparam logic [5:0] A_CT = {ADCSEQ_IDX_CTRL, 2'b00};
    localparam logic [5:0] A_MX = {ADCSEQ_IDX_MUX, 2'b00};
    // Stimulus
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          cyc_i = 1'b0;
    logic          stb_i = 1'b0;
    logic          we_i  = 1'b0;
    logic [5:0]    adr_i = 6'h00;
    logic [3:0]    sel_i = 4'h1;
    logic [31:0]   dat_i = 32'h0000_0000;
    logic          sleep_i = 1'b0;
    logic          vec_i = 1'b0;
    // Observed
    logic [31:0]   dat_o;
    logic          ack_o;
    logic          done_irq_o;
    logic          wake_o;
    logic          analog_on_o;
    logic          sample_o;
    adcseq_front_t front_o;
    logic [9:0]    code;
    logic [7:0]    rd;
    logic          irq_q = 1'b0;
    int            n_errors = 0;
    int            n_checks = 0;
    int            cyc_cnt = 0;
    int            n_samp = 0;
    int            samp_last = 0;
    int            samp_prev = 0;
    int            done_cyc = 0;
    int            p;
    int            k;

    always #5 clk_i = ~clk_i;

    adcseq_top #(.PRESCALE_W(7)) i_adcseq_top (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .cpu_quiet_sleep_i(sleep_i),
        .vector_taken_i(vec_i), .done_irq_o(done_irq_o),
        .wake_o(wake_o), .code_i(code), .analog_on_o(analog_on_o),
        .sample_o(sample_o), .front_o(front_o)
    );

    adcseq_front_model i_adcseq_front_model (
        .clk_i(clk_i), .analog_on_i(analog_on_o), .sample_i(sample_o),
        .front_i(front_o), .code_o(code)
    );

    // Ends the run with the verdict
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cycle count, sample instants, flag rise and the hang limit
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        irq_q <= done_irq_o;
        if (sample_o === 1'b1) begin
            samp_prev <= samp_last;
            samp_last <= cyc_cnt;
            n_samp <= n_samp + 1;
        end
        if (done_irq_o === 1'b1 && irq_q !== 1'b1) begin
            done_cyc <= cyc_cnt;
        end
        if (cyc_cnt == 20000) begin
            n_errors = n_errors + 1;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        n_checks++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // One classic cycle; holds everything until ack is sampled
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        chk("ack", 1'b1, ack_o);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [5:0] a,
                       input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(nm, e, rd);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (done_irq_o !== 1'b1 && n < 600) begin
            @(posedge clk_i);
            n++;
        end
        chk("irq up", 1'b1, done_irq_o);
    endtask

    task automatic pulse_vec();
        vec_i <= 1'b1;
        @(posedge clk_i);
        vec_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("irq clr", 1'b0, done_irq_o);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, read-back and an unmapped place
        rdc("mux rst", A_MX, 8'h00);
        rdc("ctl rst", A_CT, 8'h00);
        wr(6'h3C, 8'hFF);
        rdc("unmapped", 6'h3C, 8'h00);
        wr(A_MX, 8'hEB);
        rdc("mux rw", A_MX, 8'hEB);
        $display("test registers finished");
        // Start requests while off are dropped
        wr(A_CT, 8'h40);
        repeat (60) @(posedge clk_i);
        rdc("off ctl", A_CT, 8'h00);
        rdc("off lo", A_LO, 8'h00);
        chk("power", 1'b0, analog_on_o);
        $display("test disabled finished");
        // Fastest divider keeps runs short; real use needs 50..200 kHz
        p = n_samp;
        wr(A_CT, 8'hC8);
        wait_irq();
        repeat (2) @(posedge clk_i);
        chk("samples", p + 2, n_samp);
        chk_rng("ext span", 46, 52, done_cyc - samp_prev);
        rdc("ctl done", A_CT, 8'h98);
        rdc("hi left", A_HI, 8'hD7);
        rdc("lo left", A_LO, 8'h40);
        wr(A_MX, 8'hCB);
        rdc("lo right", A_LO, 8'h5D);
        rdc("hi right", A_HI, 8'h03);
        wr(A_CT, 8'h98);
        rdc("flag wr1", A_CT, 8'h88);
        $display("test single finished");
        // Reference change waits for completion
        wr(A_CT, 8'hC8);
        // Let the conversion start before the reference moves
        repeat (6) @(posedge clk_i);
        wr(A_MX, 8'h0B);
        chk("ref held", 2'b11, front_o.ref_sel);
        wait_irq();
        repeat (2) @(posedge clk_i);
        chk_rng("norm span", 21, 25, done_cyc - samp_last);
        chk("ref new", 2'b00, front_o.ref_sel);
        rdc("old ref", A_HI, 8'h03);
        $display("test reference finished");
        // Free running relaunches without software
        wr(A_CT, 8'hF8);
        // Let the old flag's request drain before waiting
        repeat (2) @(posedge clk_i);
        wait_irq();
        pulse_vec();
        wait_irq();
        rdc("fr ctl", A_CT, 8'hF8);
        chk("fr period", 26, samp_last - samp_prev);
        wr(A_CT, 8'h88);
        repeat (60) @(posedge clk_i);
        rdc("fr off", A_CT, 8'h98);
        p = n_samp;
        repeat (100) @(posedge clk_i);
        chk("fr stop", p, n_samp);
        rdc("fr code", A_HI, 8'h00);
        $display("test free run finished");
        // Switching off mid-conversion
        wr(A_CT, 8'hD8);
        repeat (10) @(posedge clk_i);
        wr(A_CT, 8'h08);
        repeat (2) @(posedge clk_i);
        chk("off", 1'b0, analog_on_o);
        repeat (100) @(posedge clk_i);
        rdc("abort ctl", A_CT, 8'h08);
        rdc("kept lo", A_LO, 8'h5D);
        $display("test abort finished");
        // Quiet conversion prep: enabled, idle, single mode, irq on
        wr(A_CT, 8'h88);
        p = n_samp;
        sleep_i <= 1'b1;
        k = 0;
        while (wake_o !== 1'b1 && k < 600) begin
            @(posedge clk_i);
            k++;
        end
        sleep_i <= 1'b0;
        chk("wake", 1'b1, wake_o);
        repeat (2) @(posedge clk_i);
        chk("wake irq", 1'b1, done_irq_o);
        chk("wake ext", p + 2, n_samp);
        pulse_vec();
        $display("test sleep finished");
        results();
    end
endmodule
